// ---- inc/nand_ctl_params.svh ----
// nand_ctl_params.svh: register map, command codes and timing for the nand flash controller
`ifndef NAND_CTL_PARAMS_SVH
`define NAND_CTL_PARAMS_SVH
// axi4-lite register byte offsets
`define REG_CMD      8'h00
`define REG_ADDR     8'h04
`define REG_TGT      8'h08
`define REG_DATA     8'h0c
`define REG_STATUS   8'h10
`define REG_CFG      8'h14
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
// software operation codes in cmd[3:0]; wdata and rdata are internal only
`define OP_READ      4'h0
`define OP_PROG      4'h1
`define OP_CONF      4'h2
`define OP_COPY      4'h3
`define OP_ERASE     4'h4
`define OP_STATUS    4'h5
`define OP_DESEL     4'h6
`define OP_WDATA     4'h7
`define OP_RDATA     4'h8
// flash command bytes
`define CMD_PTR_A    8'h00
`define CMD_PTR_B    8'h01
`define CMD_PTR_C    8'h50
`define CMD_PROG     8'h80
`define CMD_CONF     8'h10
`define CMD_ERASE    8'h60
`define CMD_ECONF    8'hd0
`define CMD_COPY     8'h8a
`define CMD_STATUS   8'h70
// area selection in cmd[5:4]
`define AREA_A       2'h0
`define AREA_B       2'h1
`define PART_LIMIT   2'h3
// timing, in ns, and derived cycle counts (rounded up)
`define CLK_NS       10
`define TWE_NS       30
`define TWB_NS       100
`define TREA_NS      30
`define TDESEL_NS    100
`define TWE_CYC      ((`TWE_NS + `CLK_NS - 1) / `CLK_NS)
`define TWB_CYC      ((`TWB_NS + `CLK_NS - 1) / `CLK_NS)
`define TREA_CYC     ((`TREA_NS + `CLK_NS - 1) / `CLK_NS)
`define TDESEL_CYC   ((`TDESEL_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_CYC     2
`endif

// ---- inc/nand_ctl_pkg.sv ----
// nand_ctl_pkg.sv: types shared by the nand flash controller
package nand_ctl_pkg;
    typedef enum logic [3:0] {K_CMD, K_ADDR, K_DATA, K_WAIT, K_RDY, K_READ, K_STAT, K_DESEL, K_END} kind_type;
    typedef enum logic [3:0] {S_IDLE, S_NEXT, S_WLO, S_WHI, S_WB, S_BUSY, S_RLO, S_RHI, S_DESEL} state_type;
    typedef struct packed {
        kind_type   kind;
        logic [7:0] val;
    } step_type;
    typedef struct packed {
        logic        ce_n;
        logic        cle;
        logic        ale;
        logic        we_n;
        logic        re_n;
        logic        wp_n;
        logic        io_oe_n;
        logic [15:0] io;
    } nand_out_type;
endpackage : nand_ctl_pkg

// ---- verilog/nand_ctl.sv ----
// nand_ctl.sv: axi4-lite driven host controller for a small-page nand flash
// Behaviour
// - pointer command precedes program setup
// - four address cycles follow read pointer
// - deselect ends sequential row read
// - at most three partial programs per page
// - setup, four addresses, data, confirm
// - copy back reads source page first
// - second cycle, target, matching top bit
// - no partial program after copy back
// - erase uses three row address cycles
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "nand_ctl_params.svh"
module nand_ctl (
    // clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_nrst,
    // axi4-lite slave
    input  wire logic [7:0]                 i_awaddr,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [31:0]                i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    output logic [1:0]                      o_bresp,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    input  wire logic [7:0]                 i_araddr,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    output logic [31:0]                     o_rdata,
    output logic [1:0]                      o_rresp,
    output logic                            o_rvalid,
    input  wire logic                       i_rready,
    // flash pins
    output nand_ctl_pkg::nand_out_type      o_nand,
    input  wire logic [15:0]                i_io,
    input  wire logic                       i_rb_n
);
    import nand_ctl_pkg::*;

    logic                rst_s1_ff;
    logic                rst_n_ff;
    logic                rb_s1_ff;
    logic                rb_ff;
    logic [15:0]         io_s1_ff;
    logic [15:0]         io_ff;
    logic                awready_ff;
    logic                bvalid_ff;
    logic [1:0]          bresp_ff;
    logic                arready_ff;
    logic                rvalid_ff;
    logic                rd_pend_ff;
    logic [1:0]          rresp_ff;
    logic [31:0]         rdata_ff;
    logic [25:0]         addr_ff;
    logic [25:0]         tgt_ff;
    logic [15:0]         wdat_ff;
    logic                x16_ff;
    logic                wp_rel_ff;
    logic [1:0]          area_ff;
    logic                refused_ff;
    logic [16:0]         page_ff;
    logic [1:0]          pcnt_ff;
    state_type           state_ff;
    logic [3:0]          op_ff;
    logic [3:0]          step_ff;
    logic [7:0]          tmr_ff;
    nand_out_type        nand_ff;
    logic [15:0]         rdat_ff;
    logic [7:0]          stat_ff;

    // row and column bytes of one 26-bit flash address, in issue order
    function automatic logic [7:0] addr_byte(input logic [25:0] a, input logic [1:0] idx);
        unique case (idx)
            2'd0: addr_byte = a[7:0];
            2'd1: addr_byte = a[16:9];
            2'd2: addr_byte = a[24:17];
            2'd3: addr_byte = {7'h00, a[25]};
        endcase
    endfunction : addr_byte

    // bus cycle sequence of each operation; step st of operation op
    // conventional command codes
    function automatic step_type step_of(input logic [3:0] op, input logic [3:0] st, input logic [7:0] ptr,
                                         input logic [25:0] a, input logic [25:0] t);
        step_type s;
        s = '{kind: K_END, val: 8'h00};
        unique case (op)
            `OP_READ: begin
                if (st == 4'd0) s = '{K_CMD, ptr};
                else if (st <= 4'd4) s = '{K_ADDR, addr_byte(a, 2'(st - 4'd1))};
                else if (st == 4'd5) s = '{K_WAIT, 8'h00};
            end
            `OP_PROG: begin
                if (st == 4'd0) s = '{K_CMD, ptr};
                else if (st == 4'd1) s = '{K_CMD, `CMD_PROG};
                else if (st <= 4'd5) s = '{K_ADDR, addr_byte(a, 2'(st - 4'd2))};
            end
            `OP_CONF: begin
                if (st == 4'd0) s = '{K_CMD, `CMD_CONF};
                else if (st == 4'd1) s = '{K_WAIT, 8'h00};
                else if (st == 4'd2) s = '{K_CMD, `CMD_STATUS};
                else if (st == 4'd3) s = '{K_STAT, 8'h00};
            end
            `OP_COPY: begin
                if (st == 4'd0) s = '{K_CMD, `CMD_PTR_A};
                else if (st <= 4'd4) s = '{K_ADDR, addr_byte(a, 2'(st - 4'd1))};
                else if (st == 4'd5) s = '{K_WAIT, 8'h00};
                else if (st == 4'd6) s = '{K_CMD, `CMD_COPY};
                else if (st <= 4'd10) s = '{K_ADDR, addr_byte(t, 2'(st - 4'd7))};
                else if (st == 4'd11) s = '{K_WAIT, 8'h00};
                else if (st == 4'd12) s = '{K_CMD, `CMD_STATUS};
                else if (st == 4'd13) s = '{K_STAT, 8'h00};
            end
            // three row cycles, last one only top bit
            `OP_ERASE: begin
                if (st == 4'd0) s = '{K_CMD, `CMD_ERASE};
                else if (st <= 4'd3) s = '{K_ADDR, addr_byte(a, st[1:0])};
                else if (st == 4'd4) s = '{K_CMD, `CMD_ECONF};
                else if (st == 4'd5) s = '{K_WAIT, 8'h00};
                else if (st == 4'd6) s = '{K_CMD, `CMD_STATUS};
                else if (st == 4'd7) s = '{K_STAT, 8'h00};
            end
            `OP_STATUS: begin
                if (st == 4'd0) s = '{K_CMD, `CMD_STATUS};
                else if (st == 4'd1) s = '{K_STAT, 8'h00};
            end
            `OP_DESEL: begin
                if (st == 4'd0) s = '{K_DESEL, 8'h00};
            end
            `OP_WDATA: begin
                if (st == 4'd0) s = '{K_DATA, 8'h00};
            end
            // wait for next page load before each strobe
            `OP_RDATA: begin
                if (st == 4'd0) s = '{K_RDY, 8'h00};
                else if (st == 4'd1) s = '{K_READ, 8'h00};
            end
            default: s = '{K_END, 8'h00};
        endcase
        return s;
    endfunction : step_of

    // reset release and pin synchronisers
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rb_s1_ff <= 1'b0;
            rb_ff    <= 1'b0;
            io_s1_ff <= 16'h0000;
            io_ff    <= 16'h0000;
        end else begin
            rb_s1_ff <= i_rb_n;
            rb_ff    <= rb_s1_ff;
            io_s1_ff <= i_io;
            io_ff    <= io_s1_ff;
        end
    end

    // decode and selection
    wire        eng_idle = state_ff == S_IDLE;
    wire        wr_go    = i_awvalid && i_wvalid && !awready_ff && !bvalid_ff && !arready_ff && !rd_pend_ff
                           && eng_idle;
    wire        rd_go    = i_arvalid && !arready_ff && !rvalid_ff && !rd_pend_ff && !awready_ff && !wr_go
                           && eng_idle;
    wire        wr_take  = awready_ff;
    wire        rd_take  = arready_ff;
    wire [3:0]  w_op     = i_wdata[3:0];
    wire        cmd_wr   = wr_take && i_awaddr == `REG_CMD;
    wire        data_wr  = wr_take && i_awaddr == `REG_DATA;
    wire        data_rd  = rd_take && i_araddr == `REG_DATA;
    wire        same_pg  = addr_ff[25:9] == page_ff;
    // no program or erase while protected
    wire        wp_block = (w_op == `OP_PROG || w_op == `OP_CONF || w_op == `OP_COPY || w_op == `OP_ERASE)
                           && !wp_rel_ff;
    // top bit of source and target must agree
    wire        top_bad  = w_op == `OP_COPY && addr_ff[25] != tgt_ff[25];
    // fourth partial program of a page refused
    wire        part_bad = w_op == `OP_PROG && same_pg && pcnt_ff == `PART_LIMIT;
    // undefined operations never reach the pins
    wire        refuse   = wp_block || top_bad || part_bad || w_op > `OP_DESEL;
    wire        launch   = (cmd_wr && !refuse) || data_wr || data_rd;
    wire [3:0]  launch_op = data_wr ? `OP_WDATA : (data_rd ? `OP_RDATA : w_op);
    // pointer byte picks column bit eight and area
    wire [7:0]  ptr_cmd  = area_ff == `AREA_A ? `CMD_PTR_A :
                           (area_ff == `AREA_B ? (x16_ff ? `CMD_PTR_A : `CMD_PTR_B) : `CMD_PTR_C);
    // spare start column keeps only low bits
    wire [7:0]  col      = area_ff[1] ? (x16_ff ? {5'h00, addr_ff[2:0]} : {4'h0, addr_ff[3:0]}) : addr_ff[7:0];
    wire [25:0] eff_addr = {addr_ff[25:8], col};
    step_type   cur;
    assign cur = step_of(op_ff, step_ff, ptr_cmd, eff_addr, tgt_ff);
    wire        tmr_done = tmr_ff == 8'h00;
    // the row read stream keeps chip enable low
    wire        keep_ce  = op_ff == `OP_READ || op_ff == `OP_PROG || op_ff == `OP_WDATA || op_ff == `OP_RDATA;
    wire        eng_end  = state_ff == S_NEXT && cur.kind == K_END;
    wire        map_hit  = i_araddr == `REG_ADDR || i_araddr == `REG_TGT || i_araddr == `REG_STATUS
                           || i_araddr == `REG_CFG || i_araddr == `REG_CMD;
    wire        wmap_hit = i_awaddr == `REG_CMD || i_awaddr == `REG_ADDR || i_awaddr == `REG_TGT
                           || i_awaddr == `REG_DATA || i_awaddr == `REG_CFG;
    // idle and failure bits shown from the captured status byte
    wire [31:0] stat_word = {14'h0000, pcnt_ff, stat_ff, 5'h00, rb_ff, refused_ff, !eng_idle};
    wire [31:0] rmux     = i_araddr == `REG_ADDR ? {6'h00, addr_ff} :
                           i_araddr == `REG_TGT ? {6'h00, tgt_ff} :
                           i_araddr == `REG_STATUS ? stat_word :
                           i_araddr == `REG_CFG ? {30'h00000000, wp_rel_ff, x16_ff} : 32'h00000000;

    // axi4-lite handshakes
    always_ff @(posedge i_clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            awready_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rd_pend_ff <= 1'b0;
            rresp_ff   <= `RESP_OKAY;
            rdata_ff   <= 32'h00000000;
        end else begin
            awready_ff <= wr_go;
            arready_ff <= rd_go;
            if (wr_take) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wmap_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_ff && i_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (data_rd) begin
                rd_pend_ff <= 1'b1;
            end else if (rd_take) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rmux;
                rresp_ff  <= map_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rd_pend_ff && eng_end) begin
                rd_pend_ff <= 1'b0;
                rvalid_ff  <= 1'b1;
                rdata_ff   <= {16'h0000, rdat_ff};
                rresp_ff   <= `RESP_OKAY;
            end else if (rvalid_ff && i_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // software registers and partial program bookkeeping
    always_ff @(posedge i_clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            addr_ff    <= 26'h0000000;
            tgt_ff     <= 26'h0000000;
            wdat_ff    <= 16'h0000;
            x16_ff     <= 1'b0;
            wp_rel_ff  <= 1'b0;
            area_ff    <= `AREA_A;
            refused_ff <= 1'b0;
            page_ff    <= 17'h00000;
            pcnt_ff    <= 2'h0;
        end else begin
            if (wr_take && i_awaddr == `REG_ADDR) addr_ff <= i_wdata[25:0];
            if (wr_take && i_awaddr == `REG_TGT) tgt_ff <= i_wdata[25:0];
            if (wr_take && i_awaddr == `REG_CFG) {wp_rel_ff, x16_ff} <= i_wdata[1:0];
            if (data_wr) wdat_ff <= i_wdata[15:0];
            if (cmd_wr) refused_ff <= refuse;
            // area is given afresh with every accepted command write, so B never lingers
            if (cmd_wr && !refuse) area_ff <= i_wdata[5:4];
            if (cmd_wr && !refuse && w_op == `OP_PROG) begin
                page_ff <= addr_ff[25:9];
                pcnt_ff <= same_pg ? pcnt_ff + 2'h1 : 2'h1;
            end
            // copy back target takes no further partial program
            if (cmd_wr && !refuse && w_op == `OP_COPY) begin
                page_ff <= tgt_ff[25:9];
                pcnt_ff <= `PART_LIMIT;
            end
            // erase of the tracked block frees its page
            if (cmd_wr && !refuse && w_op == `OP_ERASE && page_ff[16:5] == addr_ff[25:14]) pcnt_ff <= 2'h0;
        end
    end

    // flash bus cycle engine
    always_ff @(posedge i_clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= S_IDLE;
            op_ff    <= `OP_STATUS;
            step_ff  <= 4'h0;
            tmr_ff   <= 8'h00;
            nand_ff  <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0,
                          io_oe_n: 1'b1, io: 16'h0000};
            rdat_ff  <= 16'h0000;
            stat_ff  <= 8'h00;
        end else begin
            nand_ff.wp_n <= wp_rel_ff;
            if (!tmr_done) tmr_ff <= tmr_ff - 8'h01;
            unique case (state_ff)
                S_IDLE: if (launch) begin
                    op_ff        <= launch_op;
                    step_ff      <= 4'h0;
                    nand_ff.ce_n <= 1'b0;
                    state_ff     <= S_NEXT;
                end
                S_NEXT: unique case (cur.kind)
                    K_CMD, K_ADDR, K_DATA: begin
                        nand_ff.cle     <= cur.kind == K_CMD;
                        nand_ff.ale     <= cur.kind == K_ADDR;
                        nand_ff.we_n    <= 1'b0;
                        nand_ff.io_oe_n <= 1'b0;
                        nand_ff.io      <= cur.kind == K_DATA ? wdat_ff : {8'h00, cur.val};
                        tmr_ff          <= 8'(`TWE_CYC);
                        state_ff        <= S_WLO;
                    end
                    // nothing is issued until busy clears
                    K_WAIT: begin
                        tmr_ff   <= 8'(`TWB_CYC);
                        state_ff <= S_WB;
                    end
                    K_RDY: state_ff <= S_BUSY;
                    K_READ, K_STAT: begin
                        nand_ff.re_n <= 1'b0;
                        tmr_ff       <= 8'(`TREA_CYC + `SYNC_CYC);
                        state_ff     <= S_RLO;
                    end
                    // chip enable high past the deselect hold time
                    K_DESEL: begin
                        nand_ff.ce_n <= 1'b1;
                        tmr_ff       <= 8'(`TDESEL_CYC);
                        state_ff     <= S_DESEL;
                    end
                    K_END: begin
                        nand_ff.ce_n <= !keep_ce;
                        state_ff     <= S_IDLE;
                    end
                endcase
                S_WLO: if (tmr_done) begin
                    nand_ff.we_n <= 1'b1;
                    tmr_ff       <= 8'(`TWE_CYC);
                    state_ff     <= S_WHI;
                end
                S_WHI: if (tmr_done) begin
                    nand_ff.cle     <= 1'b0;
                    nand_ff.ale     <= 1'b0;
                    nand_ff.io_oe_n <= 1'b1;
                    step_ff         <= step_ff + 4'h1;
                    state_ff        <= S_NEXT;
                end
                S_WB: if (tmr_done) state_ff <= S_BUSY;
                S_BUSY: if (rb_ff) begin
                    step_ff  <= step_ff + 4'h1;
                    state_ff <= S_NEXT;
                end
                // status byte captured after each program or erase
                S_RLO: if (tmr_done) begin
                    if (cur.kind == K_STAT) stat_ff <= io_ff[7:0];
                    else rdat_ff <= x16_ff ? io_ff : {8'h00, io_ff[7:0]};
                    nand_ff.re_n <= 1'b1;
                    tmr_ff       <= 8'(`TWE_CYC);
                    state_ff     <= S_RHI;
                end
                S_RHI, S_DESEL: if (tmr_done) begin
                    step_ff  <= step_ff + 4'h1;
                    state_ff <= S_NEXT;
                end
            endcase
        end
    end

    assign o_awready = awready_ff;
    assign o_wready  = awready_ff;
    assign o_bvalid  = bvalid_ff;
    assign o_bresp   = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid  = rvalid_ff;
    assign o_rresp   = rresp_ff;
    assign o_rdata   = rdata_ff;
    assign o_nand    = nand_ff;
endmodule : nand_ctl

// ---- tb/nand_ctl_properties.sv ----
// pin and response checker for the nand flash controller
`timescale 1ns/1ps
module nand_ctl_props
    import nand_ctl_pkg::*;
(
    // clock and reset
    input wire logic                  i_clock,
    input wire logic                  i_nrst,
    // bus responses
    input wire logic                  o_bvalid,
    input wire logic                  i_bready,
    input wire logic [1:0]            o_bresp,
    input wire logic                  o_rvalid,
    input wire logic                  i_rready,
    input wire logic [31:0]           o_rdata,
    // flash pins
    input wire nand_ctl_pkg::nand_out_type o_nand
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    a_ce_strobe: assert property (!o_nand.we_n || !o_nand.re_n |-> !o_nand.ce_n)
        else $error("strobe while deselected");
    a_latch_excl: assert property (!(o_nand.cle && o_nand.ale))
        else $error("both latch enables high");
    a_we_drive: assert property (!o_nand.we_n |-> !o_nand.io_oe_n)
        else $error("write strobe with bus released");
    a_we_width: assert property ($fell(o_nand.we_n) |-> !o_nand.we_n [*3])
        else $error("write pulse too short");
    a_re_width: assert property ($fell(o_nand.re_n) |-> !o_nand.re_n [*5])
        else $error("read pulse too short");
    a_re_release: assert property (!o_nand.re_n |-> o_nand.io_oe_n && o_nand.we_n)
        else $error("bus driven during read");
endmodule : nand_ctl_props
bind nand_ctl nand_ctl_props i_props (.i_clock, .i_nrst, .o_bvalid, .i_bready, .o_bresp, .o_rvalid,
    .i_rready, .o_rdata, .o_nand);

// ---- tb/flash_model.sv ----
// behavioural x8 small-page flash answering the controller pins
`timescale 1ns/1ps
module flash_model
    import nand_ctl_pkg::*;
(
    // pins and resolved bus
    input  wire nand_ctl_pkg::nand_out_type i_pins,
    input  wire logic [15:0]                i_bus,
    // device outputs
    output logic [15:0]                     o_io,
    output logic                            o_rb_n
);
    logic [7:0]  cmd, prev, col, base;
    logic [1:0]  area;
    logic [15:0] last;
    int          nadr;
    initial begin
        {cmd, prev, col, base, area, last, o_io} = '0;
        nadr = 0;
        o_rb_n = 1'b1;
    end
    task automatic busy(input int t);
        o_rb_n = 1'b0;
        #(t);
        o_rb_n = 1'b1;
    endtask : busy
    always @(posedge i_pins.we_n) if (!i_pins.ce_n && i_pins.cle) begin
        nadr = 0;
        prev = cmd;
        if (i_bus[7:0] inside {8'h00, 8'h01, 8'h50}) area = i_bus[6] ? 2'h2 : i_bus[1:0];
        // protect low drops program and erase setups
        cmd = (i_bus[7:0] inside {8'h80, 8'h60} && !i_pins.wp_n) ? 8'hff : i_bus[7:0];
        // confirm only after its setup; busy ignores all
        if ((cmd == 8'h10 && prev == 8'h80) || (cmd == 8'hd0 && prev == 8'h60)) begin
            busy(300);
            cmd = 8'h70;
        end
    end else if (!i_pins.ce_n && i_pins.ale) begin
        // spare start takes only the low column bits
        if (nadr == 0) col = (area == 2'h2) ? {4'h0, i_bus[3:0]} : i_bus[7:0];
        nadr++;
        // fourth address loads the page; area b is one-shot
        if (nadr == 4 && cmd inside {8'h00, 8'h01, 8'h50}) begin
            base = {area, 6'h0};
            if (area == 2'h1) area = 2'h0;
            busy(200);
        end
        // copy back programs with no confirm
        if (nadr == 4 && cmd == 8'h8a) begin
            busy(300);
            cmd = 8'h70;
        end
    end
    // status shows idle and pass; data streams by column
    always @(negedge i_pins.re_n) if (!i_pins.ce_n) begin
        o_io = (cmd == 8'h70) ? {8'h0, i_pins.wp_n, o_rb_n, 6'h0} : {8'h0, base + col};
        if (cmd != 8'h70) col++;
        last = o_io;
    end
    // released bus shows the inverse so a stale value cannot pass
    always @(posedge i_pins.re_n) #15 o_io = ~last;
endmodule : flash_model

// ---- tb/nand_ctl_bench.sv ----
// self-checking bench for the nand flash controller
`timescale 1ns/1ps
`include "nand_ctl_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module nand_ctl_bench;
    import nand_ctl_pkg::*;
    logic         i_clock = 1'b0, i_nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic         arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, rb_n;
    logic [7:0]   awaddr = 8'h0, araddr = 8'h0;
    logic [31:0]  wdata = 32'h0, rdata, d;
    logic [1:0]   bresp, rresp;
    logic [15:0]  mio, bus;
    nand_out_type pins;
    int           error_cnt = 0, n_tests = 0;
    logic [31:0]  ca[5] = '{32'h00, 32'h10, 32'h20, 32'h10, 32'h20};
    logic [31:0]  ad[5] = '{32'h05, 32'h03, 32'h35, 32'h03, 32'h3d};
    logic [31:0]  ex[5] = '{32'h05, 32'h43, 32'h85, 32'h03, 32'h85};
    always #5 i_clock = ~i_clock;
    assign bus = pins.io_oe_n ? mio : pins.io;
    nand_ctl i_nand_ctl (.i_clock(i_clock), .i_nrst(i_nrst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .o_nand(pins), .i_io(bus), .i_rb_n(rb_n));
    flash_model i_flash_model (.i_pins(pins), .i_bus(bus), .o_io(mio), .o_rb_n(rb_n));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_ok = 1'b0, w_ok = 1'b0;
        @(posedge i_clock);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released at its own ready
        do begin
            @(posedge i_clock);
            if (awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        do @(posedge i_clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, `RESP_OKAY)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge i_clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge i_clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge i_clock); while (rvalid !== 1'b1);
        v = rdata;
        rready <= 1'b0;
        `CHK(rresp, er)
    endtask : rd
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        rd(`REG_STATUS, `RESP_OKAY, v);
        `CHK(v & m, e)
    endtask : st
    task final_report;
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // watchdog sized well above the whole sequence
    initial begin
        #400us;
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clock);
        `CHK(pins.wp_n, 1'b0)
        wr(`REG_CFG, 32'h2);
        for (int i = 0; i < 5; i++) begin
            // x16 organisation for the last two reads
            if (i == 3) wr(`REG_CFG, 32'h3);
            wr(`REG_ADDR, ad[i]);
            wr(`REG_CMD, ca[i]);
            rd(`REG_DATA, `RESP_OKAY, d);
            `CHK(d, ex[i])
            rd(`REG_DATA, `RESP_OKAY, d);
            `CHK(d, ex[i] + 32'h1)
        end
        wr(`REG_CFG, 32'h2);
        wr(`REG_ADDR, 32'h200);
        // only three partial programs per page
        for (int i = 0; i < 4; i++) begin
            wr(`REG_CMD, 32'h01);
            st(32'h2, {30'h0, i == 3, 1'b0});
            if (i < 3) begin
                wr(`REG_DATA, 32'h5a);
                wr(`REG_CMD, 32'h02);
                st(32'hff07, 32'hc004);
            end
        end
        wr(`REG_CFG, 32'h0);
        wr(`REG_CMD, 32'h04);
        st(32'h2, 32'h2);
        wr(`REG_CFG, 32'h2);
        wr(`REG_CMD, 32'h04);
        st(32'hff07, 32'hc004);
        wr(`REG_CMD, 32'h01);
        st(32'h2, 32'h0);
        wr(`REG_CMD, 32'h02);
        wr(`REG_TGT, 32'h2000000);
        wr(`REG_CMD, 32'h03);
        st(32'h2, 32'h2);
        wr(`REG_TGT, 32'h400);
        wr(`REG_CMD, 32'h03);
        st(32'hff07, 32'hc004);
        wr(`REG_ADDR, 32'h400);
        wr(`REG_CMD, 32'h01);
        st(32'h2, 32'h2);
        wr(`REG_CMD, 32'h07);
        st(32'h2, 32'h2);
        rd(8'h18, `RESP_SLVERR, d);
        `CHK(d, 32'h0)
        wr(`REG_CMD, 32'h06);
        st(32'h1, 32'h0);
        `CHK(pins.ce_n, 1'b1)
        final_report;
    end
endmodule : nand_ctl_bench
